// file: pkg/sdc_pkg.sv
// Constants and types shared by the serial drive command slave.
// Assumes a byte UART on the same clock and a 10-bit (8N1) character.
// Behaviour
// - Only functions 03 read, 06 write.
// - Bad function or locked target: error frame.
// - Read reply: address, function, count, data, CRC.
// - CRC low byte first; write is address, value.
// - ASCII write reply echoes the request exactly.
// - ASCII LRC checked on receive, made on send.
// - Command bits 1:0 run, bit 4 reset.
// - Command bits 3:2 select the direction.
// - Setpoint 0 to 40000 in 0.01 Hz.
// - Source 5 runs from the serial setpoint.
// - Source 0 runs from main frequency parameter.
// - Parameter group.index sits at group*100+index.
// - Acceleration time written in tenths of seconds.
// - Baud selection 1 means 9600 baud.
// - Format 0 selects ASCII 8N1.
// - Format 3 selects RTU 8N1.
package sdc_pkg;
	localparam int unsigned CLK_HZ       = 40_000_000;
	localparam logic [7:0]  FC_READ      = 8'h03;
	localparam logic [7:0]  FC_WRITE     = 8'h06;
	localparam logic [7:0]  ERR_DATA     = 8'h00;
	localparam logic [7:0]  CH_COLON     = 8'h3a;
	localparam logic [7:0]  CH_CR        = 8'h0d;
	localparam logic [7:0]  CH_LF        = 8'h0a;
	localparam logic [15:0] REG_RUN_CMD  = 16'h2000;
	localparam logic [15:0] REG_FREQ_SET = 16'h2001;
	localparam logic [15:0] SETPOINT_MAX = 16'h9c40;
	localparam logic [15:0] ADDR_CURRENT = 16'h0003;
	localparam logic [15:0] ADDR_SPEED   = 16'h0005;
	localparam logic [15:0] ADDR_MAIN_F  = 16'h0064;
	localparam logic [15:0] ADDR_F_SRC   = 16'h0065;
	localparam logic [15:0] ADDR_ACCEL   = 16'h006b;
	localparam logic [15:0] ADDR_DECEL   = 16'h006c;
	localparam logic [15:0] ADDR_BAUD    = 16'h02bc;
	localparam logic [15:0] ADDR_FORMAT  = 16'h02bd;
	localparam logic [15:0] ADDR_STATION = 16'h02be;
	localparam logic [15:0] PARAM_FIRST_WR = 16'h0064;
	localparam logic [15:0] PARAM_LAST   = 16'h03e7;
	localparam int          PARAM_AW     = 10;
	localparam int          PARAM_DEPTH  = 1024;
	localparam logic [15:0] MAX_RD_WORDS = 16'h0004;
	localparam logic [15:0] STATION_MAX  = 16'h00f7;
	localparam logic [15:0] FSRC_MAIN    = 16'h0000;
	localparam logic [15:0] FSRC_SERIAL  = 16'h0005;
	localparam logic [15:0] FMT_ASCII    = 16'h0000;
	localparam logic [15:0] FMT_RTU      = 16'h0003;
	localparam logic [15:0] BAUD_SEL_MAX = 16'h0003;
	localparam int unsigned BAUD_0       = 4800;
	localparam int unsigned BAUD_1       = 9600;
	localparam int unsigned BAUD_2       = 19200;
	localparam int unsigned BAUD_3       = 38400;
	localparam int unsigned CHAR_BITS    = 10;
	localparam int unsigned GAP_HALF_CHARS = 7;
	localparam logic [3:0]  RX_MAX       = 4'h8;
	localparam logic [3:0]  RX_LEN_ASCII = 4'h7;
	localparam logic [3:0]  RX_LEN_RTU   = 4'h8;
	localparam logic [15:0] CRC_INIT     = 16'hffff;
	localparam logic [15:0] CRC_POLY     = 16'ha001;
	localparam logic [15:0] RST_MAIN_F   = 16'h1388;
	localparam logic [15:0] RST_F_SRC    = 16'h0000;
	localparam logic [15:0] RST_ACCEL    = 16'h0064;
	localparam logic [15:0] RST_DECEL    = 16'h0064;
	localparam logic [15:0] RST_BAUD     = 16'h0001;
	localparam logic [15:0] RST_FORMAT   = 16'h0000;
	localparam logic [15:0] RST_STATION  = 16'h0001;
	localparam int          CMD_RUN_LSB  = 0;
	localparam int          CMD_DIR_LSB  = 2;
	localparam int          CMD_RST_BIT  = 4;

	typedef enum logic [1:0] {RUN_NONE, RUN_STOP, RUN_START, RUN_JOG} sdc_run_t;
	typedef enum logic [1:0] {DIR_NONE, DIR_REV, DIR_FWD, DIR_TOGGLE} sdc_dir_t;
	typedef enum logic [1:0] {REP_ERR, REP_ECHO, REP_READ} sdc_rep_t;
	typedef struct packed {
		sdc_run_t run;
		sdc_dir_t dir;
		logic     fault_reset;
	} sdc_cmd_t;
endpackage

// file: tb/sdc_master_model.sv
// Behavioural serial bus master that stands on the far side of the slave.
// Assumes one character or byte per rx_valid pulse, and a tx byte handshake.
`timescale 1ns/1ps
module sdc_master_model (
	// Clock.
	input  wire logic       clk,
	// Characters to the slave.
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	// Characters from the slave.
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	// ****************************************
	// Link behaviour
	// ****************************************
	logic       slow;
	logic [7:0] got[$];
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
		slow = 1'b0;
	end
	// In slow mode every other cycle stalls the reply.
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
	// A released data line shows the inverse, so no stale byte looks valid.
	task automatic send(input logic [7:0] c[$]);
		foreach (c[i]) begin
			@(posedge clk);
			rx_data <= c[i];
			rx_valid <= 1'b1;
			@(posedge clk);
			rx_valid <= 1'b0;
			rx_data <= ~c[i];
			repeat (2) @(posedge clk);
		end
	endtask
endmodule

// file: tb/sdc_slave_tb.sv
// Self-checking bench for the slave in ASCII framing, then one read in RTU framing.
// Assumes the master model drives the link and collects the replies.
`timescale 1ns/1ps
module sdc_slave_tb;
	// ****************************************
	// Bench
	// ****************************************
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [7:0]        rx_data, tx_data;
	logic              rx_valid, tx_valid, tx_ready;
	logic [15:0]       mon_current = 16'h0120;
	logic [15:0]       mon_speed = 16'h0456;
	sdc_pkg::sdc_cmd_t cmd;
	logic              cmd_strobe;
	logic [15:0]       freq_ref, accel_time, decel_time;
	logic [19:0]       baud_div;
	logic              ascii_mode;
	int                err_count = 0;
	int                n_compared = 0;
	int                strobes = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk) if (cmd_strobe === 1'b1) strobes++;
	sdc_slave u_dut (.clk(clk), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .mon_current(mon_current), .mon_speed(mon_speed), .cmd(cmd),
		.cmd_strobe(cmd_strobe), .freq_ref(freq_ref), .accel_time(accel_time), .decel_time(decel_time),
		.baud_div(baud_div), .ascii_mode(ascii_mode));
	sdc_master_model u_master (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready));
	task automatic check(input string what, input logic [19:0] exp, input logic [19:0] seen);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	function automatic void mk(input logic [7:0] b[$], output logic [7:0] c[$]);
		logic [7:0] s;
		s = 8'h00;
		c = '{8'h3a};
		foreach (b[i]) s += b[i];
		b.push_back(-s);
		foreach (b[i]) for (int h = 1; h >= 0; h--) c.push_back((b[i][4*h+:4] < 10) ? 8'h30 + b[i][4*h+:4] : 8'h37 + b[i][4*h+:4]);
		c.push_back(8'h0d);
		c.push_back(8'h0a);
	endfunction
	task automatic run(input string nm, input logic [7:0] req[$], input logic [7:0] exp[$], input bit bad);
		logic [7:0] c[$], e[$];
		mk(req, c);
		if (bad) c[c.size()-3] = (c[c.size()-3] == 8'h30) ? 8'h31 : 8'h30;
		if (exp.size() > 0) mk(exp, e);
		u_master.got.delete();
		u_master.send(c);
		collect(e, 2000);
		$display("test %s done", nm);
	endtask
	function automatic void crc_app(inout logic [7:0] b[$]);
		logic [15:0] r;
		r = sdc_pkg::CRC_INIT;
		foreach (b[i]) begin
			r ^= {8'h00, b[i]};
			for (int k = 0; k < 8; k++) r = r[0] ? ((r >> 1) ^ sdc_pkg::CRC_POLY) : (r >> 1);
		end
		b.push_back(r[7:0]);
		b.push_back(r[15:8]);
	endfunction
	task automatic rtu(input string nm, input logic [7:0] req[$], input logic [7:0] exp[$]);
		crc_app(req);
		crc_app(exp);
		u_master.got.delete();
		u_master.send(req);
		collect(exp, 40000);
		$display("test %s done", nm);
	endtask
	task automatic collect(input logic [7:0] e[$], input int lim);
		int k;
		for (k = 0; k < lim && u_master.got.size() < ((e.size() > 0) ? e.size() : 1); k++) @(posedge clk);
		if (k == lim && e.size() > 0) begin
			err_count++;
			$display("unexpected reply timeout: expected %0d chars, seen %0d", e.size(), u_master.got.size());
			final_report();
		end
		repeat (8) @(posedge clk);
		check("reply length", e.size(), u_master.got.size());
		foreach (e[i]) if (i < u_master.got.size()) check("reply char", e[i], u_master.got[i]);
	endtask
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("baud_div", 20'd4166, baud_div);
		check("ascii_mode", 1'b1, ascii_mode);
		run("start", '{8'h01, 8'h06, 8'h20, 8'h00, 8'h00, 8'h02}, '{8'h01, 8'h06, 8'h20, 8'h00, 8'h00, 8'h02}, 0);
		check("cmd", {sdc_pkg::RUN_START, sdc_pkg::DIR_NONE, 1'b0}, cmd);
		check("strobes", 1, strobes);
		u_master.slow = 1'b1;
		run("stop fwd reset", '{8'h01, 8'h06, 8'h20, 8'h00, 8'h00, 8'h19}, '{8'h01, 8'h06, 8'h20, 8'h00, 8'h00, 8'h19}, 0);
		check("cmd", {sdc_pkg::RUN_STOP, sdc_pkg::DIR_FWD, 1'b1}, cmd);
		run("source serial", '{8'h01, 8'h06, 8'h00, 8'h65, 8'h00, 8'h05}, '{8'h01, 8'h06, 8'h00, 8'h65, 8'h00, 8'h05}, 0);
		run("setpoint max", '{8'h01, 8'h06, 8'h20, 8'h01, 8'h9c, 8'h40}, '{8'h01, 8'h06, 8'h20, 8'h01, 8'h9c, 8'h40}, 0);
		check("freq_ref", 16'h9c40, freq_ref);
		run("setpoint over", '{8'h01, 8'h06, 8'h20, 8'h01, 8'h9c, 8'h41}, '{8'h01, 8'h06, 8'h00}, 0);
		check("freq_ref", 16'h9c40, freq_ref);
		run("source main", '{8'h01, 8'h06, 8'h00, 8'h65, 8'h00, 8'h00}, '{8'h01, 8'h06, 8'h00, 8'h65, 8'h00, 8'h00}, 0);
		check("freq_ref", 16'h1388, freq_ref);
		run("accel", '{8'h01, 8'h06, 8'h00, 8'h6b, 8'h00, 8'hc8}, '{8'h01, 8'h06, 8'h00, 8'h6b, 8'h00, 8'hc8}, 0);
		check("accel_time", 16'h00c8, accel_time);
		run("read", '{8'h01, 8'h03, 8'h00, 8'h64, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h13, 8'h88}, 0);
		run("bad function", '{8'h01, 8'h05, 8'h00, 8'h64, 8'h00, 8'h01}, '{8'h01, 8'h05, 8'h00}, 0);
		run("bad check", '{8'h01, 8'h06, 8'h20, 8'h00, 8'h00, 8'h01}, '{}, 1);
		run("other station", '{8'h02, 8'h06, 8'h20, 8'h00, 8'h00, 8'h01}, '{}, 0);
		check("strobes", 2, strobes);
		run("baud fast", '{8'h01, 8'h06, 8'h02, 8'hbc, 8'h00, 8'h03}, '{8'h01, 8'h06, 8'h02, 8'hbc, 8'h00, 8'h03}, 0);
		run("format rtu", '{8'h01, 8'h06, 8'h02, 8'hbd, 8'h00, 8'h03}, '{8'h01, 8'h06, 8'h02, 8'hbd, 8'h00, 8'h03}, 0);
		repeat (4) @(posedge clk);
		check("ascii_mode", 1'b0, ascii_mode);
		check("baud_div", 20'(sdc_pkg::CLK_HZ / sdc_pkg::BAUD_3), baud_div);
		check("decel_time", sdc_pkg::RST_DECEL, decel_time);
		rtu("rtu read", '{8'h01, 8'h03, 8'h00, 8'h03, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h01, 8'h20});
		final_report();
	end
endmodule

// file: verilog/sdc_crc16.sv
// One-byte step of the reflected 16-bit frame CRC.
// Purely combinational; the caller holds the running value.
`timescale 1ns/1ps
module sdc_crc16 (
	// Running value and new byte.
	input  wire logic [15:0] crc_in,
	input  wire logic [7:0]  data,
	// Updated value.
	output logic [15:0]      crc_out
);
	always_comb begin
		crc_out = crc_in ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			crc_out = crc_out[0] ? ((crc_out >> 1) ^ sdc_pkg::CRC_POLY) : (crc_out >> 1);
		end
	end
endmodule

// file: verilog/sdc_param_ram.sv
// Parameter store, one word per decimal parameter address.
// Assumes the caller screens addresses; contents are not reset.
`timescale 1ns/1ps
module sdc_param_ram (
	// Clock.
	input  wire logic                          clk,
	// Write port.
	input  wire logic                          we,
	input  wire logic [sdc_pkg::PARAM_AW-1:0] waddr,
	input  wire logic [15:0]                   wdata,
	// Registered read port.
	input  wire logic [sdc_pkg::PARAM_AW-1:0] raddr,
	output logic [15:0]                        rdata
);
	logic [15:0] mem_r [0:sdc_pkg::PARAM_DEPTH-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem_r[waddr] <= wdata;
		end
		rdata <= mem_r[raddr];
	end
endmodule

// file: verilog/sdc_slave.sv
// Frame interpreter for the drive's serial control port, slave side.
// Assumes a byte UART on clk; it follows baud_div and ascii_mode.
`timescale 1ns/1ps
module sdc_slave #(
	parameter int unsigned CLK_HZ = sdc_pkg::CLK_HZ
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Received bytes.
	input  wire logic [7:0]   rx_data,
	input  wire logic         rx_valid,
	// Bytes to send.
	output logic [7:0]        tx_data,
	output logic              tx_valid,
	input  wire logic         tx_ready,
	// Drive monitors.
	input  wire logic [15:0]  mon_current,
	input  wire logic [15:0]  mon_speed,
	// Drive controls and UART link settings.
	output sdc_pkg::sdc_cmd_t cmd,
	output logic              cmd_strobe,
	output logic [15:0]       freq_ref,
	output logic [15:0]       accel_time,
	output logic [15:0]       decel_time,
	output logic [19:0]       baud_div,
	output logic              ascii_mode
);
	// ************************************************************
	// Helpers.
	// ************************************************************
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) return {1'b1, 4'(c - 8'h30)};
		if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c - 8'h37)};
		if (c >= 8'h61 && c <= 8'h66) return {1'b1, 4'(c - 8'h57)};
		return 5'h00;
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < 4'ha) ? 8'(8'h30 + n) : 8'(8'h37 + n);
	endfunction

	function automatic logic [19:0] div_of(input logic [15:0] sel);
		case (sel[1:0])
			2'h0:    return 20'(CLK_HZ / sdc_pkg::BAUD_0);
			2'h1:    return 20'(CLK_HZ / sdc_pkg::BAUD_1);
			2'h2:    return 20'(CLK_HZ / sdc_pkg::BAUD_2);
			default: return 20'(CLK_HZ / sdc_pkg::BAUD_3);
		endcase
	endfunction

	typedef enum logic [2:0] {S_IDLE, S_RX, S_CHECK, S_EXEC, S_FETCH, S_LOAD, S_SEND} sdc_st_t;

	sdc_st_t           st_r, st_nxt;
	logic [7:0]        rxb_r [0:7];
	logic [7:0]        rxb_nxt [0:7];
	logic [3:0]        rxn_r, rxn_nxt, rxn_base;
	logic              half_r, half_nxt;
	logic [3:0]        hi_r, hi_nxt;
	logic [7:0]        sum_r, sum_nxt;
	logic [15:0]       crc_r, crc_nxt, crc_base, crc_step;
	logic [23:0]       gap_r, gap_nxt;
	sdc_pkg::sdc_rep_t rep_r, rep_nxt;
	logic [3:0]        len_r, len_nxt, idx_r, idx_nxt, last_idx, widx;
	logic              colon_r, colon_nxt, nib_r, nib_nxt, raw_r, raw_nxt;
	logic [7:0]        cur_r, cur_nxt, tsum_r, tsum_nxt;
	logic [15:0]       tcrc_r, tcrc_nxt, tcrc_step;
	logic [7:0]        txd_r, txd_nxt;
	logic              txv_r, txv_nxt;
	logic [4:0]        hx;
	logic [7:0]        push_byte;
	logic              push;
	logic [15:0]       wreg, wval, rd_addr, ram_q, rd_word;
	logic              is_rd, is_wr, cmd_wr, setp_wr, par_wr, rd_ok, exec_ok, frame_ok;

	assign hx        = hex_val(rx_data);
	assign push_byte = ascii_mode ? {hi_r, hx[3:0]} : rx_data;
	assign rxn_base  = (st_r == S_IDLE) ? 4'h0 : rxn_r;
	assign crc_base  = (st_r == S_IDLE) ? sdc_pkg::CRC_INIT : crc_r;
	assign wreg      = {rxb_r[2], rxb_r[3]};
	assign wval      = {rxb_r[4], rxb_r[5]};
	assign is_rd     = rxb_r[1] == sdc_pkg::FC_READ;
	assign is_wr     = rxb_r[1] == sdc_pkg::FC_WRITE;
	assign last_idx  = ascii_mode ? 4'(len_r + 4'h2) : 4'(len_r + 4'h1);
	assign widx      = 4'(idx_r - 4'h3) >> 1;
	assign rd_addr   = 16'(wreg + {12'h000, widx});

	sdc_crc16 u_rx_crc (
		.crc_in  (crc_base),
		.data    (push_byte),
		.crc_out (crc_step)
	);

	sdc_crc16 u_tx_crc (
		.crc_in  (tcrc_r),
		.data    (cur_r),
		.crc_out (tcrc_step)
	);

	// ************************************************************
	// Configuration and drive command registers.
	// ************************************************************
	logic [15:0]       mainf_r, mainf_nxt, fsrc_r, fsrc_nxt, accel_r, accel_nxt, decel_r, decel_nxt;
	logic [15:0]       baud_r, baud_nxt, fmt_r, fmt_nxt, stn_r, stn_nxt, setp_r, setp_nxt, fref_r, fref_nxt;
	logic [19:0]       bdiv_r, bdiv_nxt;
	logic [23:0]       gap_lim_r, gap_lim_nxt;
	logic              ascii_r, ascii_nxt, strobe_r, strobe_nxt;
	sdc_pkg::sdc_cmd_t cmd_r, cmd_nxt;

	// Group 0 holds monitors and is write protected.
	assign cmd_wr  = st_r == S_EXEC && is_wr && wreg == sdc_pkg::REG_RUN_CMD;
	assign setp_wr = st_r == S_EXEC && is_wr && wreg == sdc_pkg::REG_FREQ_SET && wval <= sdc_pkg::SETPOINT_MAX;
	assign par_wr  = st_r == S_EXEC && is_wr && wreg >= sdc_pkg::PARAM_FIRST_WR && wreg <= sdc_pkg::PARAM_LAST
		&& !(wreg == sdc_pkg::ADDR_BAUD && wval > sdc_pkg::BAUD_SEL_MAX)
		&& !(wreg == sdc_pkg::ADDR_FORMAT && wval != sdc_pkg::FMT_ASCII && wval != sdc_pkg::FMT_RTU)
		&& !(wreg == sdc_pkg::ADDR_STATION && (wval == 16'h0000 || wval > sdc_pkg::STATION_MAX));
	assign rd_ok   = is_rd && wval != 16'h0000 && wval <= sdc_pkg::MAX_RD_WORDS
		&& 17'({1'b0, wreg} + {1'b0, wval}) <= 17'({1'b0, sdc_pkg::PARAM_LAST} + 17'h00001);
	assign exec_ok = rd_ok || cmd_wr || setp_wr || par_wr;

	always_comb begin
		mainf_nxt   = mainf_r;
		fsrc_nxt    = fsrc_r;
		accel_nxt   = accel_r;
		decel_nxt   = decel_r;
		baud_nxt    = baud_r;
		fmt_nxt     = fmt_r;
		stn_nxt     = stn_r;
		setp_nxt    = setp_wr ? wval : setp_r;
		cmd_nxt     = cmd_r;
		strobe_nxt  = cmd_wr;
		bdiv_nxt    = bdiv_r;
		gap_lim_nxt = gap_lim_r;
		ascii_nxt   = ascii_r;
		fref_nxt    = fref_r;
		if (cmd_wr) begin
			cmd_nxt.run         = sdc_pkg::sdc_run_t'(wval[sdc_pkg::CMD_RUN_LSB +: 2]);
			cmd_nxt.dir         = sdc_pkg::sdc_dir_t'(wval[sdc_pkg::CMD_DIR_LSB +: 2]);
			cmd_nxt.fault_reset = wval[sdc_pkg::CMD_RST_BIT];
		end
		if (par_wr) begin
			case (wreg)
				sdc_pkg::ADDR_MAIN_F:  mainf_nxt = wval;
				sdc_pkg::ADDR_F_SRC:   fsrc_nxt  = wval;
				sdc_pkg::ADDR_ACCEL:   accel_nxt = wval;
				sdc_pkg::ADDR_DECEL:   decel_nxt = wval;
				sdc_pkg::ADDR_BAUD:    baud_nxt  = wval;
				sdc_pkg::ADDR_FORMAT:  fmt_nxt   = wval;
				sdc_pkg::ADDR_STATION: stn_nxt   = wval;
				default:               mainf_nxt = mainf_r;
			endcase
		end
		// Link settings change only between frames so a reply leaves in the mode it was asked in.
		if (st_r == S_IDLE) begin
			bdiv_nxt    = div_of(baud_r);
			gap_lim_nxt = 24'(bdiv_r * sdc_pkg::CHAR_BITS * sdc_pkg::GAP_HALF_CHARS / 2);
			ascii_nxt   = fmt_r == sdc_pkg::FMT_ASCII;
		end
		if (fsrc_r == sdc_pkg::FSRC_SERIAL) begin
			fref_nxt = setp_r;
		end else if (fsrc_r == sdc_pkg::FSRC_MAIN) begin
			fref_nxt = mainf_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mainf_r   <= sdc_pkg::RST_MAIN_F;
			fsrc_r    <= sdc_pkg::RST_F_SRC;
			accel_r   <= sdc_pkg::RST_ACCEL;
			decel_r   <= sdc_pkg::RST_DECEL;
			baud_r    <= sdc_pkg::RST_BAUD;
			fmt_r     <= sdc_pkg::RST_FORMAT;
			stn_r     <= sdc_pkg::RST_STATION;
			setp_r    <= 16'h0000;
			cmd_r     <= '0;
			strobe_r  <= 1'b0;
			bdiv_r    <= 20'h00000;
			gap_lim_r <= 24'hffffff;
			ascii_r   <= 1'b1;
			fref_r    <= 16'h0000;
		end else begin
			mainf_r   <= mainf_nxt;
			fsrc_r    <= fsrc_nxt;
			accel_r   <= accel_nxt;
			decel_r   <= decel_nxt;
			baud_r    <= baud_nxt;
			fmt_r     <= fmt_nxt;
			stn_r     <= stn_nxt;
			setp_r    <= setp_nxt;
			cmd_r     <= cmd_nxt;
			strobe_r  <= strobe_nxt;
			bdiv_r    <= bdiv_nxt;
			gap_lim_r <= gap_lim_nxt;
			ascii_r   <= ascii_nxt;
			fref_r    <= fref_nxt;
		end
	end

	sdc_param_ram u_ram (
		.clk   (clk),
		.we    (par_wr),
		.waddr (wreg[sdc_pkg::PARAM_AW-1:0]),
		.wdata (wval),
		.raddr (rd_addr[sdc_pkg::PARAM_AW-1:0]),
		.rdata (ram_q)
	);

	// Shadowed and monitored words bypass the store, which is never cleared.
	always_comb begin
		case (rd_addr)
			sdc_pkg::ADDR_CURRENT: rd_word = mon_current;
			sdc_pkg::ADDR_SPEED:   rd_word = mon_speed;
			sdc_pkg::ADDR_MAIN_F:  rd_word = mainf_r;
			sdc_pkg::ADDR_F_SRC:   rd_word = fsrc_r;
			sdc_pkg::ADDR_ACCEL:   rd_word = accel_r;
			sdc_pkg::ADDR_DECEL:   rd_word = decel_r;
			sdc_pkg::ADDR_BAUD:    rd_word = baud_r;
			sdc_pkg::ADDR_FORMAT:  rd_word = fmt_r;
			sdc_pkg::ADDR_STATION: rd_word = stn_r;
			default:               rd_word = ram_q;
		endcase
	end

	// ************************************************************
	// Frame receive, decision and reply.
	// ************************************************************
	assign frame_ok = (ascii_mode ? sum_r == 8'h00 : crc_r == 16'h0000)
		&& rxn_r >= (ascii_mode ? 4'h3 : 4'h4) && rxn_r <= sdc_pkg::RX_MAX
		&& {8'h00, rxb_r[0]} == stn_r
		&& (!(is_rd || is_wr) || rxn_r == (ascii_mode ? sdc_pkg::RX_LEN_ASCII : sdc_pkg::RX_LEN_RTU));

	always_comb begin
		st_nxt    = st_r;
		rxb_nxt   = rxb_r;
		rxn_nxt   = rxn_r;
		half_nxt  = half_r;
		hi_nxt    = hi_r;
		sum_nxt   = sum_r;
		crc_nxt   = crc_r;
		rep_nxt   = rep_r;
		len_nxt   = len_r;
		idx_nxt   = idx_r;
		colon_nxt = colon_r;
		nib_nxt   = nib_r;
		raw_nxt   = raw_r;
		cur_nxt   = cur_r;
		tsum_nxt  = tsum_r;
		tcrc_nxt  = tcrc_r;
		txd_nxt   = txd_r;
		txv_nxt   = txv_r;
		push      = 1'b0;
		gap_nxt   = rx_valid ? 24'h000000 : ((&gap_r) ? gap_r : 24'(gap_r + 24'h000001));
		case (st_r)
			S_IDLE, S_RX: begin
				if (rx_valid && ascii_mode) begin
					if (rx_data == sdc_pkg::CH_COLON) begin
						st_nxt   = S_RX;
						rxn_nxt  = 4'h0;
						sum_nxt  = 8'h00;
						half_nxt = 1'b0;
					end else if (st_r == S_RX && rx_data == sdc_pkg::CH_LF) begin
						st_nxt = S_CHECK;
					end else if (st_r == S_RX && rx_data != sdc_pkg::CH_CR) begin
						if (!hx[4]) begin
							st_nxt = S_IDLE;
						end else if (!half_r) begin
							half_nxt = 1'b1;
							hi_nxt   = hx[3:0];
						end else begin
							half_nxt = 1'b0;
							push     = 1'b1;
						end
					end
				end else if (rx_valid) begin
					st_nxt = S_RX;
					push   = 1'b1;
				end else if (st_r == S_RX && !ascii_mode && gap_r >= gap_lim_r) begin
					st_nxt = S_CHECK;
				end
				if (push) begin
					if (rxn_base < sdc_pkg::RX_MAX) begin
						rxb_nxt[rxn_base[2:0]] = push_byte;
					end
					rxn_nxt = (rxn_base > sdc_pkg::RX_MAX) ? rxn_base : 4'(rxn_base + 4'h1);
					sum_nxt = 8'(sum_r + push_byte);
					crc_nxt = crc_step;
				end
			end
			S_CHECK: begin
				st_nxt = frame_ok ? S_EXEC : S_IDLE;
			end
			S_EXEC: begin
				rep_nxt   = !exec_ok ? sdc_pkg::REP_ERR : (is_rd ? sdc_pkg::REP_READ : sdc_pkg::REP_ECHO);
				len_nxt   = !exec_ok ? 4'h3 : (is_rd ? 4'(4'h3 + {wval[2:0], 1'b0}) : 4'h6);
				idx_nxt   = 4'h0;
				tsum_nxt  = 8'h00;
				tcrc_nxt  = sdc_pkg::CRC_INIT;
				nib_nxt   = 1'b0;
				colon_nxt = ascii_mode;
				raw_nxt   = 1'b1;
				cur_nxt   = sdc_pkg::CH_COLON;
				st_nxt    = ascii_mode ? S_SEND : S_FETCH;
			end
			S_FETCH: begin
				st_nxt = S_LOAD;
			end
			S_LOAD: begin
				raw_nxt = !ascii_mode;
				st_nxt  = S_SEND;
				if (idx_r < len_r) begin
					if (idx_r < 4'h2 || rep_r == sdc_pkg::REP_ECHO) begin
						cur_nxt = rxb_r[idx_r[2:0]];
					end else if (rep_r == sdc_pkg::REP_ERR) begin
						cur_nxt = sdc_pkg::ERR_DATA;
					end else if (idx_r == 4'h2) begin
						cur_nxt = {wval[6:0], 1'b0};
					end else begin
						cur_nxt = idx_r[0] ? rd_word[15:8] : rd_word[7:0];
					end
					tsum_nxt = 8'(tsum_r + cur_nxt);
				end else if (ascii_mode) begin
					cur_nxt = (idx_r == len_r) ? 8'(8'h00 - tsum_r)
						: ((idx_r == 4'(len_r + 4'h1)) ? sdc_pkg::CH_CR : sdc_pkg::CH_LF);
					raw_nxt = idx_r != len_r;
				end else begin
					cur_nxt = (idx_r == len_r) ? tcrc_r[7:0] : tcrc_r[15:8];
				end
			end
			S_SEND: begin
				if (!txv_r) begin
					txv_nxt = 1'b1;
					txd_nxt = raw_r ? cur_r : hex_char(nib_r ? cur_r[3:0] : cur_r[7:4]);
				end else if (tx_ready) begin
					txv_nxt = 1'b0;
					nib_nxt = !raw_r && !nib_r;
					if (!raw_r && !nib_r) begin
						st_nxt = S_SEND;
					end else if (colon_r) begin
						colon_nxt = 1'b0;
						st_nxt    = S_FETCH;
					end else if (idx_r == last_idx) begin
						st_nxt = S_IDLE;
					end else begin
						idx_nxt = 4'(idx_r + 4'h1);
						st_nxt  = S_FETCH;
						// The check word takes each data byte once it has left, so the byte choice stays off its path.
						if (idx_r < len_r) begin
							tcrc_nxt = tcrc_step;
						end
					end
				end
			end
			default: begin
				st_nxt = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r    <= S_IDLE;
			rxb_r   <= '{default: 8'h00};
			rxn_r   <= 4'h0;
			half_r  <= 1'b0;
			hi_r    <= 4'h0;
			sum_r   <= 8'h00;
			crc_r   <= sdc_pkg::CRC_INIT;
			gap_r   <= 24'h000000;
			rep_r   <= sdc_pkg::REP_ERR;
			len_r   <= 4'h0;
			idx_r   <= 4'h0;
			colon_r <= 1'b0;
			nib_r   <= 1'b0;
			raw_r   <= 1'b0;
			cur_r   <= 8'h00;
			tsum_r  <= 8'h00;
			tcrc_r  <= sdc_pkg::CRC_INIT;
			txd_r   <= 8'h00;
			txv_r   <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			rxb_r   <= rxb_nxt;
			rxn_r   <= rxn_nxt;
			half_r  <= half_nxt;
			hi_r    <= hi_nxt;
			sum_r   <= sum_nxt;
			crc_r   <= crc_nxt;
			gap_r   <= gap_nxt;
			rep_r   <= rep_nxt;
			len_r   <= len_nxt;
			idx_r   <= idx_nxt;
			colon_r <= colon_nxt;
			nib_r   <= nib_nxt;
			raw_r   <= raw_nxt;
			cur_r   <= cur_nxt;
			tsum_r  <= tsum_nxt;
			tcrc_r  <= tcrc_nxt;
			txd_r   <= txd_nxt;
			txv_r   <= txv_nxt;
		end
	end

	assign tx_data    = txd_r;
	assign tx_valid   = txv_r;
	assign cmd        = cmd_r;
	assign cmd_strobe = strobe_r;
	assign freq_ref   = fref_r;
	assign accel_time = accel_r;
	assign decel_time = decel_r;
	assign baud_div   = bdiv_r;
	assign ascii_mode = ascii_r;

	// ************************************************************
	// Checks.
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_func_unknown: assert property (st_r == S_EXEC && !is_rd && !is_wr |=> rep_r == sdc_pkg::REP_ERR)
		else $error("unsupported function not refused");
	a_err_byte: assert property (st_r == S_LOAD && rep_r == sdc_pkg::REP_ERR && idx_r == 4'h2 |=> cur_r == 8'h00)
		else $error("error frame data byte not zero");
	a_read_len: assert property (st_r == S_EXEC && rd_ok |=> len_r == 4'(4'h3 + {wval[2:0], 1'b0}))
		else $error("read reply length wrong");
	a_crc_low_first: assert property (st_r == S_LOAD && !ascii_mode && idx_r == len_r |=> cur_r == $past(tcrc_r[7:0]))
		else $error("crc low byte not first");
	a_echo_copy: assert property (st_r == S_LOAD && rep_r == sdc_pkg::REP_ECHO && idx_r == 4'h4 |=> cur_r == rxb_r[4])
		else $error("echo byte differs");
	a_lrc_sum: assert property (st_r == S_LOAD && ascii_mode && idx_r == len_r |=> 8'(cur_r + tsum_r) == 8'h00)
		else $error("lrc does not cancel sum");
	a_cmd_fields: assert property (cmd_wr |=> strobe_r && cmd_r.run == $past(wval[1:0])
		&& cmd_r.dir == $past(wval[3:2]) && cmd_r.fault_reset == $past(wval[4]))
		else $error("command word decode wrong");
	a_setp_limit: assert property (setp_r <= sdc_pkg::SETPOINT_MAX)
		else $error("setpoint above limit");
	a_freq_sources: assert property (
		(rst_n && fsrc_r == sdc_pkg::FSRC_SERIAL ##1 fsrc_r == sdc_pkg::FSRC_SERIAL |-> freq_ref == $past(setp_r))
		and (rst_n && fsrc_r == sdc_pkg::FSRC_MAIN ##1 fsrc_r == sdc_pkg::FSRC_MAIN |-> freq_ref == $past(mainf_r)))
		else $error("frequency source mux wrong");
	a_accel_store: assert property (par_wr && wreg == sdc_pkg::ADDR_ACCEL |=> accel_time == $past(wval))
		else $error("parameter 107 not stored");
	a_baud_9600: assert property (rst_n && st_r == S_IDLE && baud_r == 16'h0001
		|=> baud_div == 20'(CLK_HZ / sdc_pkg::BAUD_1))
		else $error("baud divider wrong");
	a_fmt_mode: assert property (st_r == S_IDLE |=> ascii_mode == ($past(fmt_r) == 16'h0000))
		else $error("framing mode wrong");
	a_foreign_quiet: assert property (st_r == S_CHECK && {8'h00, rxb_r[0]} != stn_r |=> st_r == S_IDLE)
		else $error("foreign frame answered");
	a_gap_end: assert property (st_r == S_RX && !ascii_mode ##1 st_r == S_CHECK |-> $past(gap_r) >= gap_lim_r)
		else $error("rtu frame ended early");

	c_echo_done: cover property (st_r == S_SEND && rep_r == sdc_pkg::REP_ECHO && txv_r && tx_ready && idx_r == last_idx);
	c_read_four: cover property (st_r == S_EXEC ##1 rep_r == sdc_pkg::REP_READ && len_r == 4'hb);
	c_error_reply: cover property (st_r == S_EXEC ##1 rep_r == sdc_pkg::REP_ERR);
endmodule
